// ### hdl/phy_mgmt_pkg.sv
// constants for the phy management, pin and wake register bank
// assumes a 25 MHz clock, one apb word per register
package phy_mgmt_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_TARGET_ADDR = 'h138;
  localparam int IDX_DATA_WORD = 'h139;
  localparam int IDX_ACCESS_CTRL = 'h13B;
  localparam int IDX_GP_PINS = 'h13D;
  localparam int IDX_WAKE_EN = 'h13E;
  localparam int IDX_BASIC_CTRL = 'h140;
  localparam int IDX_BASIC_STAT = 'h142;
  localparam int IDX_AN_ADV = 'h144;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GO_BIT = 6;
  localparam int DIR_BIT = 5;
  localparam int GP0_DIR_BIT = 0;
  localparam int GP0_VAL_BIT = 1;
  localparam int GP1_DIR_BIT = 2;
  localparam int GP1_VAL_BIT = 3;
  localparam int CTL_RESET_BIT = 15;
  localparam int CTL_SPEED_BIT = 13;
  localparam int CTL_ANE_BIT = 12;
  localparam int CTL_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int ADV_RF_BIT = 13;
  localparam int ADV_ABIL_LSB = 5;

  // ---------------------------------------------------------------
  // reset values and constant fields
  // ---------------------------------------------------------------
  localparam logic [4:0] STAT_CAPS = 5'h0F;
  localparam logic [3:0] ADV_ABIL_RST = 4'hF;
  localparam logic [4:0] ADV_SEL_RST = 5'h01;
  localparam logic [6:0] WAKE_RST = 7'h00;

  // ---------------------------------------------------------------
  // management frame timing and layout
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC =
    (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_BITS = 64;
  localparam int TA_FIRST_BIT = 46;
  localparam int DATA_FIRST_BIT = 48;
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;

  typedef enum {MG_IDLE, MG_RUN} mgmt_state_e;

  function automatic logic [ADDR_W-1:0] byte_addr(input int idx);
    byte_addr = ADDR_W'(idx * 4);
  endfunction : byte_addr

endpackage : phy_mgmt_pkg

// ### hdl/pin_sync.sv
// two-stage synchroniser for levels arriving from pins
// assumes the inputs are asynchronous to mclk
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : pin_sync

// ### hdl/mgmt_frame_engine.sv
// serial management frame engine on mdc/mdio
// assumes mdio_in is synchronised to mclk
`timescale 1ns/1ns
module mgmt_frame_engine (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic write_op,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] reg_idx,
  input wire logic [15:0] wdata,
  input wire logic mdio_in,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe
);

  phy_mgmt_pkg::mgmt_state_e state;
  logic [phy_mgmt_pkg::FRAME_BITS-1:0] shreg;
  logic [6:0] bit_cnt;
  logic [3:0] div;
  logic is_write;

  wire half_tick = div == 4'(phy_mgmt_pkg::MDC_HALF_CYC - 1);
  wire last_bit = bit_cnt == 7'(phy_mgmt_pkg::FRAME_BITS - 1);
  wire in_data = bit_cnt >= 7'(phy_mgmt_pkg::DATA_FIRST_BIT);
  wire next_oe = is_write ||
    (bit_cnt + 7'h01) < 7'(phy_mgmt_pkg::TA_FIRST_BIT);
  wire [phy_mgmt_pkg::FRAME_BITS-1:0] frame = {phy_mgmt_pkg::PREAMBLE,
    phy_mgmt_pkg::START_CODE,
    write_op ? phy_mgmt_pkg::OP_WRITE : phy_mgmt_pkg::OP_READ,
    phy_addr, reg_idx,
    write_op ? phy_mgmt_pkg::TA_WRITE : 2'h0,
    write_op ? wdata : 16'h0000};

  assign busy = state == phy_mgmt_pkg::MG_RUN;
  assign mdio_o = shreg[phy_mgmt_pkg::FRAME_BITS-1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= phy_mgmt_pkg::MG_IDLE;
      shreg <= '0;
      bit_cnt <= 7'h00;
      div <= 4'h0;
      is_write <= 1'b0;
      mdc <= 1'b0;
      mdio_oe <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      case (state)
        phy_mgmt_pkg::MG_IDLE: begin
          if (start) begin // R24
            shreg <= frame;
            is_write <= write_op;
            bit_cnt <= 7'h00;
            div <= 4'h0;
            mdc <= 1'b0;
            mdio_oe <= 1'b1;
            state <= phy_mgmt_pkg::MG_RUN;
          end
        end
        phy_mgmt_pkg::MG_RUN: begin
          if (!half_tick) begin
            div <= div + 4'h1;
          end else begin
            div <= 4'h0;
            mdc <= !mdc;
            if (!mdc && in_data && !is_write) begin
              rdata <= {rdata[14:0], mdio_in}; // R24
            end
            if (mdc) begin
              shreg <= {shreg[phy_mgmt_pkg::FRAME_BITS-2:0], 1'b1};
              bit_cnt <= bit_cnt + 7'h01;
              mdio_oe <= next_oe && !last_bit;
              if (last_bit) begin
                done <= 1'b1;
                state <= phy_mgmt_pkg::MG_IDLE;
              end
            end
          end
        end
        default: state <= phy_mgmt_pkg::MG_IDLE;
      endcase
    end
  end

endmodule : mgmt_frame_engine

// ### hdl/phy_mgmt_gpio_wake_regs.sv
// apb register bank: phy management, general pins, wake, phy words
// assumes events on mclk; pins are synchronised here
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
// Function
// [R1] go bit starts frame, self-clears when done
// [R2] direction picks write or read
// [R3] 16-bit data word both ways
// [R4] writable target phy address
// [R5] pin one driven when output
// [R6] pin zero driven when output
// [R7] input pin value bits ignore writes
// [R8] read-only external phy support flag
// [R9] seven wake enables reset to zero
// [R10] wakeup needs feature and enabled event
// [R11] reset bit restores defaults, self-clears
// [R12] speed bit, loaded from eeprom
// [R13] autoneg on: speed, duplex show result
// [R14] restart bit re-initiates autoneg
// [R15] duplex bit, loaded from eeprom
// [R16] constant capability bits in status
// [R17] autoneg complete status bit
// [R18] remote fault sticky, cleared by read
// [R19] next page zero, ack read-only
// [R20] remote fault advert writable, reset zero
// [R21] pause advert read-only from eeprom
// [R22] ability adverts writable default one
// [R23] selector writable default one
// [R24] serial management frame to phy
module phy_mgmt_gpio_wake_regs #(
  parameter logic EXT_PHY_SUPPORT = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic mdio_i,
  output logic general_pin_0_o,
  output logic general_pin_0_oe,
  input wire logic general_pin_0_i,
  output logic general_pin_1_o,
  output logic general_pin_1_oe,
  input wire logic general_pin_1_i,
  input wire logic set_feature_wakeup,
  input wire logic link_change_evt,
  input wire logic special_packet_evt,
  input wire logic [4:0] wake_frame_evt,
  output logic remote_wakeup,
  input wire logic ee_load,
  input wire logic ee_speed,
  input wire logic ee_duplex,
  input wire logic ee_autoneg,
  input wire logic ee_pause,
  input wire logic an_complete,
  input wire logic an_speed,
  input wire logic an_duplex,
  input wire logic an_partner_ack,
  input wire logic remote_fault_evt,
  output logic speed_100,
  output logic full_duplex,
  output logic autoneg_enable,
  output logic an_restart,
  output logic phy_soft_reset,
  output logic [3:0] adv_abilities
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [4:0] phy_target_addr, phy_reg_index, adv_selector;
  logic [15:0] mgmt_data_word, eng_rdata;
  logic mgmt_go, mgmt_direction, mgmt_start;
  logic gp0_direction, gp0_value, gp1_direction, gp1_value;
  logic [6:0] wake_en;
  logic ctl_speed, ctl_duplex, an_done, remote_fault;
  logic adv_ack, remote_fault_adv, pause_adv;
  logic mdio_sync, eng_busy, eng_done;
  logic [1:0] gp_sync;

  // ---------------------------------------------------------------
  // pin synchronisers and management engine
  // ---------------------------------------------------------------
  pin_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({general_pin_1_i, general_pin_0_i, mdio_i}),
    .sync_out({gp_sync, mdio_sync})
  );

  mgmt_frame_engine u_engine (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(mgmt_start),
    .write_op(mgmt_direction),
    .phy_addr(phy_target_addr),
    .reg_idx(phy_reg_index),
    .wdata(mgmt_data_word),
    .mdio_in(mdio_sync),
    .busy(eng_busy),
    .done(eng_done),
    .rdata(eng_rdata),
    .mdc(mdc),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input int idx);
    hit = a == phy_mgmt_pkg::byte_addr(idx);
  endfunction : hit

  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire sel_target = hit(paddr, phy_mgmt_pkg::IDX_TARGET_ADDR);
  wire sel_data = hit(paddr, phy_mgmt_pkg::IDX_DATA_WORD);
  wire sel_access = hit(paddr, phy_mgmt_pkg::IDX_ACCESS_CTRL);
  wire sel_gp = hit(paddr, phy_mgmt_pkg::IDX_GP_PINS);
  wire sel_wake = hit(paddr, phy_mgmt_pkg::IDX_WAKE_EN);
  wire sel_ctl = hit(paddr, phy_mgmt_pkg::IDX_BASIC_CTRL);
  wire sel_stat = hit(paddr, phy_mgmt_pkg::IDX_BASIC_STAT);
  wire sel_adv = hit(paddr, phy_mgmt_pkg::IDX_AN_ADV);
  wire mapped = sel_target || sel_data || sel_access || sel_gp ||
    sel_wake || sel_ctl || sel_stat || sel_adv;
  wire mgmt_idle = !mgmt_go && !eng_busy;

  wire wr_target = wr && sel_target && mgmt_idle;
  wire wr_data = wr && sel_data && mgmt_idle;
  wire wr_access = wr && sel_access && mgmt_idle;
  wire wr_gp = wr && sel_gp;
  wire wr_wake = wr && sel_wake;
  wire wr_ctl = wr && sel_ctl;
  wire wr_adv = wr && sel_adv;
  wire rd_stat = rd && sel_stat;

  wire ctl_reset_req = wr_ctl && pwdata[phy_mgmt_pkg::CTL_RESET_BIT];

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire gp0_read = gp0_direction ? gp0_value : gp_sync[0]; // R6
  wire gp1_read = gp1_direction ? gp1_value : gp_sync[1]; // R5
  wire shown_speed = autoneg_enable ? an_speed : ctl_speed; // R13
  wire shown_duplex = autoneg_enable ? an_duplex : ctl_duplex; // R13

  wire [7:0] rd_access = {1'b0, mgmt_go, mgmt_direction,
    phy_reg_index};
  wire [7:0] rd_gp = {3'h0, EXT_PHY_SUPPORT, gp1_read, gp1_direction,
    gp0_read, gp0_direction}; // R8
  wire [15:0] rd_ctl = {phy_soft_reset, 1'b0, shown_speed,
    autoneg_enable, 2'h0, an_restart, shown_duplex, 8'h00};
  wire [15:0] rd_stat_word = {1'b0, 4'hF, 5'h00, an_done,
    remote_fault, phy_mgmt_pkg::STAT_CAPS[3:0] & 4'h9}; // R16
  wire [15:0] rd_adv = {1'b0, adv_ack, remote_fault_adv, 2'h0,
    pause_adv, 1'b0, adv_abilities, adv_selector}; // R19 R21 R22

  wire [15:0] rd_word =
    sel_target ? {11'h000, phy_target_addr} :
    sel_data ? mgmt_data_word :
    sel_access ? {8'h00, rd_access} :
    sel_gp ? {8'h00, rd_gp} :
    sel_wake ? {9'h000, wake_en} :
    sel_ctl ? rd_ctl :
    sel_stat ? rd_stat_word :
    sel_adv ? rd_adv : 16'h0000;

  // ---------------------------------------------------------------
  // apb slave: one wait state, error on unmapped address
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // ---------------------------------------------------------------
  // management access
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phy_target_addr <= 5'h00;
      mgmt_direction <= 1'b0;
      phy_reg_index <= 5'h00;
    end else begin
      if (wr_target) begin
        phy_target_addr <= pwdata[4:0]; // R4
      end
      if (wr_access) begin
        mgmt_direction <= pwdata[phy_mgmt_pkg::DIR_BIT]; // R2
        phy_reg_index <= pwdata[4:0]; // R2
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_go <= 1'b0;
      mgmt_start <= 1'b0;
    end else begin
      mgmt_start <= wr_access && pwdata[phy_mgmt_pkg::GO_BIT]; // R1
      if (wr_access && pwdata[phy_mgmt_pkg::GO_BIT]) begin
        mgmt_go <= 1'b1; // R1
      end else if (eng_done) begin
        mgmt_go <= 1'b0; // R1
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_data_word <= 16'h0000;
    end else if (eng_done && !mgmt_direction) begin
      mgmt_data_word <= eng_rdata; // R3
    end else if (wr_data) begin
      mgmt_data_word <= pwdata[15:0]; // R3
    end
  end

  // ---------------------------------------------------------------
  // general pins
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gp0_direction <= 1'b0;
      gp0_value <= 1'b0;
      gp1_direction <= 1'b0;
      gp1_value <= 1'b0;
      general_pin_0_o <= 1'b0;
      general_pin_0_oe <= 1'b0;
      general_pin_1_o <= 1'b0;
      general_pin_1_oe <= 1'b0;
    end else begin
      if (wr_gp) begin
        gp0_direction <= pwdata[phy_mgmt_pkg::GP0_DIR_BIT];
        gp1_direction <= pwdata[phy_mgmt_pkg::GP1_DIR_BIT];
      end
      if (wr_gp && gp0_direction) begin
        gp0_value <= pwdata[phy_mgmt_pkg::GP0_VAL_BIT]; // R7
      end
      if (wr_gp && gp1_direction) begin
        gp1_value <= pwdata[phy_mgmt_pkg::GP1_VAL_BIT]; // R7
      end
      general_pin_0_o <= gp0_value; // R6
      general_pin_0_oe <= gp0_direction; // R6
      general_pin_1_o <= gp1_value; // R5
      general_pin_1_oe <= gp1_direction; // R5
    end
  end

  // ---------------------------------------------------------------
  // wake enables and remote wakeup
  // ---------------------------------------------------------------
  wire [6:0] wake_hit = wake_en &
    {link_change_evt, special_packet_evt, wake_frame_evt};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_en <= phy_mgmt_pkg::WAKE_RST; // R9
      remote_wakeup <= 1'b0;
    end else begin
      if (wr_wake) begin
        wake_en <= pwdata[6:0]; // R9
      end
      remote_wakeup <= set_feature_wakeup && (|wake_hit); // R10
    end
  end

  // ---------------------------------------------------------------
  // phy basic control
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_speed <= 1'b0;
      ctl_duplex <= 1'b0;
      autoneg_enable <= 1'b0;
      an_restart <= 1'b0;
      phy_soft_reset <= 1'b0;
    end else begin
      phy_soft_reset <= ctl_reset_req; // R11
      an_restart <= wr_ctl && !ctl_reset_req &&
        pwdata[phy_mgmt_pkg::CTL_RESTART_BIT]; // R14
      if (ee_load || ctl_reset_req) begin
        ctl_speed <= ee_speed; // R11 R12
        ctl_duplex <= ee_duplex; // R11 R15
        autoneg_enable <= ee_autoneg; // R11
      end else if (wr_ctl) begin
        autoneg_enable <= pwdata[phy_mgmt_pkg::CTL_ANE_BIT];
        if (!autoneg_enable) begin
          ctl_speed <= pwdata[phy_mgmt_pkg::CTL_SPEED_BIT]; // R12 R13
          ctl_duplex <= pwdata[phy_mgmt_pkg::CTL_DUPLEX_BIT]; // R15 R13
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
    end else begin
      speed_100 <= shown_speed; // R13
      full_duplex <= shown_duplex; // R13
    end
  end

  // ---------------------------------------------------------------
  // phy basic status
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      an_done <= 1'b0;
      remote_fault <= 1'b0;
    end else begin
      an_done <= an_complete && !ctl_reset_req; // R17
      if (remote_fault_evt) begin
        remote_fault <= 1'b1; // R18
      end else if (rd_stat || ctl_reset_req) begin
        remote_fault <= 1'b0; // R18 R11
      end
    end
  end

  // ---------------------------------------------------------------
  // auto-negotiation advertisement
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      adv_ack <= 1'b0;
      remote_fault_adv <= 1'b0;
      pause_adv <= 1'b0;
      adv_abilities <= phy_mgmt_pkg::ADV_ABIL_RST;
      adv_selector <= phy_mgmt_pkg::ADV_SEL_RST;
    end else begin
      adv_ack <= an_partner_ack; // R19
      if (ee_load) begin
        pause_adv <= ee_pause; // R21
      end
      if (wr_adv) begin
        remote_fault_adv <= pwdata[phy_mgmt_pkg::ADV_RF_BIT]; // R20
        adv_abilities <= pwdata[phy_mgmt_pkg::ADV_ABIL_LSB +: 4]; // R22
        adv_selector <= pwdata[4:0]; // R23
      end
    end
  end

endmodule : phy_mgmt_gpio_wake_regs

// ### verification/phy_mgmt_gpio_wake_regs_monitor.sv
// checker for the phy management register bank
// assumes binding to the bank; sees its ports only
`timescale 1ns/1ns
module phy_mgmt_gpio_wake_regs_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic general_pin_0_oe,
  input wire logic general_pin_1_oe,
  input wire logic set_feature_wakeup,
  input wire logic remote_wakeup,
  input wire logic ee_load,
  input wire logic an_speed,
  input wire logic an_duplex,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic autoneg_enable,
  input wire logic an_restart,
  input wire logic phy_soft_reset,
  input wire logic [3:0] adv_abilities
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_wake_needs_feature: assert property (
    remote_wakeup |-> $past(set_feature_wakeup)) else $error("wake early");
  a_restart_cause: assert property (
    an_restart |-> $past(pready && pwrite && paddr == 12'h500 &&
      pwdata[9]) ##1 !an_restart) else $error("restart pulse bad");
  a_softrst_cause: assert property (
    phy_soft_reset |-> $past(pready && pwrite && paddr == 12'h500 &&
      pwdata[15]) ##1 !phy_soft_reset) else $error("soft reset bad");
  a_speed_result: assert property (
    autoneg_enable && !pready && !ee_load |=> speed_100 == $past(an_speed)
      && full_duplex == $past(an_duplex)) else $error("not an result");
  a_mdc_half: assert property (
    $rose(mdc) |-> mdc [*5] ##1 !mdc) else $error("mdc high time");
  a_mdio_on_fall: assert property (
    $changed(mdio_o) && mdio_oe && $past(mdio_oe) |-> $fell(mdc))
    else $error("mdio moved off mdc fall");
  a_adv_by_write: assert property (
    $changed(adv_abilities) |-> $past(pready && pwrite && paddr == 12'h510))
    else $error("advert changed alone");
  a_pin0_by_write: assert property (
    $changed(general_pin_0_oe) |-> $past(pready && pwrite &&
      paddr == 12'h4F4, 2)) else $error("pin0 enable changed alone");
  a_pin1_by_write: assert property (
    $changed(general_pin_1_oe) |-> $past(pready && pwrite &&
      paddr == 12'h4F4, 2)) else $error("pin1 enable changed alone");
endmodule : phy_mgmt_gpio_wake_regs_monitor

bind phy_mgmt_gpio_wake_regs phy_mgmt_gpio_wake_regs_monitor i_mon (.*);

// ### verification/mgmt_phy_model.sv
// serial management phy model: 32 registers behind mdc/mdio
// assumes a pull-up on mdio and one frame at a time
`timescale 1ns/1ns
module mgmt_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h09
) (
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  output logic mdio_i
);
  // ------------------------------------------------------------
  // frame decode and read answer
  // ------------------------------------------------------------
  logic [15:0] regs [32];
  logic [15:0] sr;
  logic [4:0] ra;
  logic rd, hit, drv, bit_o;
  int cnt;
  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 16'hA500 | 16'(i);
    cnt = 64;
    drv = 1'b0;
    bit_o = 1'b1;
  end
  assign mdio_i = mdio_oe ? mdio_o : (drv ? bit_o : 1'b1);
  always @(posedge mdio_oe) cnt = 0;
  always @(posedge mdc) begin
    sr = {sr[14:0], mdio_o};
    cnt++;
    if (cnt == 46) begin
      rd = sr[11:10] == 2'h2;
      hit = sr[9:5] == PHY_ADDR;
      ra = sr[4:0];
    end
    if (cnt == 64 && !rd && hit) regs[ra] = sr;
  end
  always @(negedge mdc) begin
    drv = rd && hit && cnt >= 47 && cnt < 64;
    bit_o = cnt == 47 ? 1'b0 : regs[ra][63 - cnt];
  end
endmodule : mgmt_phy_model

// ### verification/phy_mgmt_gpio_wake_regs_bench.sv
// self-checking bench for the phy management bank
// assumes the phy model on mdio and held general pins
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("BAD %s exp %h got %h", nm, exp, got); \
  end \
end
module phy_mgmt_gpio_wake_regs_bench;
  // ------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic mdc, mdio_o, mdio_oe, mdio_i, set_feature_wakeup;
  logic general_pin_0_o, general_pin_0_oe, general_pin_1_o;
  logic general_pin_1_oe, link_change_evt, special_packet_evt;
  logic [4:0] wake_frame_evt;
  logic remote_wakeup, ee_load, ee_speed, ee_duplex, ee_autoneg;
  logic ee_pause, an_complete, an_speed, an_duplex, an_partner_ack;
  logic remote_fault_evt, speed_100, full_duplex, autoneg_enable;
  logic an_restart, phy_soft_reset;
  logic [3:0] adv_abilities;
  logic [1:0] pin_ext;
  int error_cnt, tests_run, wake_seen, rs_seen;
  wire general_pin_0_i = general_pin_0_oe ? general_pin_0_o : pin_ext[0];
  wire general_pin_1_i = general_pin_1_oe ? general_pin_1_o : pin_ext[1];
  phy_mgmt_gpio_wake_regs i_dut (.*);
  mgmt_phy_model i_phy (.*);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    wake_seen += int'(remote_wakeup === 1'b1);
    rs_seen += int'(an_restart === 1'b1);
  end
  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) error_cnt++;
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [11:0] a,
    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, rv)
  endtask : rdc
  task automatic poll();
    int n = 0;
    apb(1'b0, 12'h4EC, 32'h0);
    `CHK("go busy", 1'b1, rv[6])
    while (rv[6] !== 1'b0 && n < 100) begin
      repeat (10) @(posedge mclk);
      apb(1'b0, 12'h4EC, 32'h0);
      n++;
    end
    `CHK("go done", 1'b0, rv[6])
  endtask : poll
  task automatic pulse(input logic [6:0] e);
    @(posedge mclk);
    {link_change_evt, special_packet_evt, wake_frame_evt} <= e;
    @(posedge mclk);
    {link_change_evt, special_packet_evt, wake_frame_evt} <= 7'h00;
    repeat (3) @(posedge mclk);
  endtask : pulse
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc("wake", 12'h4F8, 32'h00);
    rdc("stat", 12'h508, 32'h7809);
    rdc("adv", 12'h510, 32'h01E1);
    rdc("gp", 12'h4F4, 32'h12);
    apb(1'b0, 12'h7FC, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask : t_reset
  task automatic t_gpio();
    wr_w(12'h4F4, 32'h0A);
    pin_ext <= 2'b10;
    repeat (3) @(posedge mclk);
    rdc("gp in", 12'h4F4, 32'h18);
    wr_w(12'h4F4, 32'h0D);
    wr_w(12'h4F4, 32'h0D);
    `CHK("gp0", 2'b10, {general_pin_0_oe, general_pin_0_o})
    `CHK("gp1", 2'b11, {general_pin_1_oe, general_pin_1_o})
  endtask : t_gpio
  task automatic wr_w(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask : wr_w
  task automatic t_mgmt();
    wr_w(12'h4E0, 32'h09);
    wr_w(12'h4E4, 32'h1234);
    wr_w(12'h4EC, 32'h63);
    wr_w(12'h4E4, 32'hFFFF);
    poll();
    `CHK("phy wr", 16'h1234, i_phy.regs[3])
    wr_w(12'h4EC, 32'h47);
    poll();
    rdc("phy rd", 12'h4E4, 32'hA507);
  endtask : t_mgmt
  task automatic t_ctrl();
    {ee_speed, ee_duplex, ee_pause, ee_load} <= 4'hF;
    @(posedge mclk);
    ee_load <= 1'b0;
    rdc("ctl ee", 12'h500, 32'h2100);
    wr_w(12'h500, 32'h0000);
    `CHK("spd dup", 2'b00, {speed_100, full_duplex})
    wr_w(12'h500, 32'h1000);
    wr_w(12'h500, 32'h1100);
    rdc("ctl an", 12'h500, 32'h3000);
    wr_w(12'h500, 32'h1200);
    `CHK("restart", 1, rs_seen)
    wr_w(12'h500, 32'h8000);
    rdc("ctl rst", 12'h500, 32'h2100);
  endtask : t_ctrl
  task automatic t_stat_adv();
    {an_complete, remote_fault_evt, an_partner_ack} <= 3'h7;
    @(posedge mclk);
    remote_fault_evt <= 1'b0;
    repeat (2) @(posedge mclk);
    rdc("rf", 12'h508, 32'h7839);
    rdc("an", 12'h508, 32'h7829);
    wr_w(12'h510, 32'hFFFF);
    rdc("adv1", 12'h510, 32'h65FF);
    wr_w(12'h510, 32'h0);
    rdc("adv0", 12'h510, 32'h4400);
    `CHK("abil", 4'h0, adv_abilities)
  endtask : t_stat_adv
  task automatic t_wake();
    wr_w(12'h4F8, 32'h7F);
    rdc("wen", 12'h4F8, 32'h7F);
    wr_w(12'h4F8, 32'h41);
    pulse(7'h01);
    set_feature_wakeup <= 1'b1;
    pulse(7'h02);
    `CHK("no wake", 0, wake_seen)
    pulse(7'h01);
    pulse(7'h40);
    pulse(7'h20);
    `CHK("wakes", 2, wake_seen)
  endtask : t_wake
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, set_feature_wakeup, link_change_evt} = '0;
    {special_packet_evt, ee_load, ee_speed, ee_duplex, ee_autoneg} = '0;
    {ee_pause, an_complete, an_duplex, an_partner_ack} = '0;
    {remote_fault_evt, paddr, pwdata, wake_frame_evt} = '0;
    an_speed = 1'b1;
    pin_ext = 2'b01;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_gpio();
    t_mgmt();
    t_ctrl();
    t_stat_adv();
    t_wake();
    end_of_test();
  end
  initial begin
    #800000;
    error_cnt++;
    end_of_test();
  end
endmodule : phy_mgmt_gpio_wake_regs_bench
